/* File: rtl/cbl_lane_decoder.sv */
// Host port lane decoder of the flash card: attribute, task file, native disk
// Operation
// R1: Host holds attribute select low for attribute
// R2: Attribute byte read: even byte low lane
// R3: Attribute word/odd: upper invalid, odd floats low
// R4: Attribute writes accept only even low byte
// R5: I/O config: select low, both enables high float
// R6: Select high with I/O strobe inhibits access
// R7: Task byte read: even/odd on low lane
// R8: Task word: odd upper, even lower lane
// R9: Task odd-byte access uses upper lane only
// R10: Task byte write takes low lane byte
// R11: Memory config: select high, memory strobes
// R12: Output enable low at power-up: native mode
// R13: Native mode hides attribute memory completely
// R14: Native data register word-wide unless eight-bit
// R15: Native low select: data word, registers low
// R16: Native high select 6h: status, control
// R17: Native register writes use lower lane only
// R18: Synchronise strobes, one access per pulse
module cbl_lane_decoder (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic attrSelectN,
   input wire logic lowLaneCardEnableN,
   input wire logic highLaneCardEnableN,
   input wire logic outputEnableN,
   input wire logic writeEnableN,
   input wire logic ioReadStrobeN,
   input wire logic ioWriteStrobeN,
   input wire logic [7:0] cardAddr,
   input wire logic [15:0] dataIn,
   input wire logic ioMappedConfig,
   input wire logic eightBitMode,
   input wire logic [7:0] statusIn,
   output logic [15:0] dataOut,
   output logic dataOeLow,
   output logic dataOeHigh,
   output logic [7:0] deviceControl,
   output logic nativeDiskMode,
   output logic modeValid
);
   // ==========================================================
   // Declarations
   logic [cbl_pkg::PIN_W-1:0] pinsA;
   logic [cbl_pkg::PIN_W-1:0] pinsB;
   logic attrNS, ceLoNS, ceHiNS, oeNS, weNS, iordNS, iowrNS;
   logic [7:0] addrS;
   logic [15:0] dataS;
   logic rdActive, wrActive, rdPrev, wrPrev, rdStart, wrStart;
   logic memStrobe, ioStrobe;
   cbl_pkg::cbl_state_e state;
   cbl_pkg::cbl_plan_s plan;
   cbl_pkg::cbl_plan_s next_plan;
   logic [1:0] bootCnt;
   logic tfWrEn, attrWrEn;
   logic [1:0] tfByteEn;
   logic [15:0] wrWord;
   logic [3:0] tfWrAddr;
   logic [6:0] attrWrAddr;
   logic [15:0] tfRd;
   logic [7:0] attrRd;
   logic [15:0] srcWord;
   logic rdLive;

   // ==========================================================
   // Pin synchronisers, two stages before any logic
   always_ff @(posedge clk) begin // R18
      pinsA <= {attrSelectN, highLaneCardEnableN, lowLaneCardEnableN, outputEnableN,
                writeEnableN, ioReadStrobeN, ioWriteStrobeN, cardAddr, dataIn};
      pinsB <= pinsA;
   end

   // Named views of the second stage
   assign attrNS = pinsB[cbl_pkg::PIN_ATTR];
   assign ceHiNS = pinsB[cbl_pkg::PIN_CE_HI];
   assign ceLoNS = pinsB[cbl_pkg::PIN_CE_LO];
   assign oeNS = pinsB[cbl_pkg::PIN_OE];
   assign weNS = pinsB[cbl_pkg::PIN_WE];
   assign iordNS = pinsB[cbl_pkg::PIN_IO_READ_STROBE];
   assign iowrNS = pinsB[cbl_pkg::PIN_IO_WRITE_STROBE];
   assign addrS = pinsB[cbl_pkg::PIN_ADDR_LSB +: 8];
   assign dataS = pinsB[cbl_pkg::PIN_DATA_LSB +: 16];

   // ==========================================================
   // Strobe qualification and edge detection
   // Memory strobes mean nothing in native mode; the output enable is the mode pin
   assign memStrobe = !nativeDiskMode && (!oeNS || !weNS);
   assign ioStrobe = !iordNS || !iowrNS;
   assign rdActive = !iordNS || (!nativeDiskMode && !oeNS);
   assign wrActive = !iowrNS || (!nativeDiskMode && !weNS);
   assign rdStart = state == cbl_pkg::ST_IDLE && rdActive && !rdPrev && !wrActive; // R18
   assign wrStart = state == cbl_pkg::ST_IDLE && wrActive && !wrPrev && !rdActive; // R18

   // Previous strobe levels
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdPrev <= 1'b1;
         wrPrev <= 1'b1;
      end else begin
         rdPrev <= rdActive;
         wrPrev <= wrActive;
      end
   end

   // ==========================================================
   // Lane plan decode for one access
   function automatic cbl_pkg::cbl_plan_s decodePlan(
      input logic attrN, input logic ceLoN, input logic ceHiN,
      input logic memS, input logic ioS, input logic [7:0] addr,
      input logic native, input logic ioCfg, input logic eightBit);
      cbl_pkg::cbl_plan_s p;
      logic isAttr;
      logic isTask;
      p = '0;
      p.ceN = {ceHiN, ceLoN};
      p.a0 = addr[0];
      isAttr = memS && !attrN; // R1
      isTask = (memS && attrN && !ioCfg) || (ioS && !attrN && ioCfg); // R5 R6 R11
      if (native) begin
         // Attribute space never decodes here
         if (ioS && !ceLoN && ceHiN) begin // R13 R15
            p.valid = 1'b1;
            p.drvLo = 1'b1;
            p.wrLo = 1'b1; // R17
            p.idx = 8'({4'h0, cbl_pkg::TF_NATIVE_BASE} + {5'h00, addr[2:0]});
            if (addr[2:0] == cbl_pkg::NATIVE_DATA_ADDR && !eightBit) begin // R14
               p.drvHi = 1'b1;
               p.wrHi = 1'b1;
            end
         end else if (ioS && ceLoN && !ceHiN && addr[2:0] == cbl_pkg::NATIVE_CTRL_ADDR) begin
            p.valid = 1'b1; // R16
            p.drvLo = 1'b1;
            p.useStat = 1'b1;
            p.ctrl = 1'b1;
         end
      end else if ((isAttr || isTask) && !(ceLoN && ceHiN)) begin // R5
         p.valid = 1'b1;
         p.attr = isAttr;
         p.idx = isAttr ? {1'b0, addr[7:1]} : {5'h00, addr[3:1]};
         unique case ({ceHiN, ceLoN})
            2'b10: begin
               p.drvLo = 1'b1;
               if (isAttr) begin
                  p.loZero = addr[0]; // R2
                  p.wrLo = !addr[0]; // R4
               end else begin
                  p.loFromHi = addr[0]; // R7
                  p.wrLo = !addr[0]; // R10
                  p.wrHi = addr[0];
                  p.hiFromLo = addr[0];
               end
            end
            2'b00: begin
               p.drvLo = 1'b1; // R8
               p.drvHi = 1'b1;
               p.hiZero = isAttr; // R3
               p.wrLo = 1'b1;
               p.wrHi = !isAttr; // R4
            end
            default: begin
               p.drvHi = 1'b1; // R9
               p.hiZero = isAttr; // R3
               p.wrHi = !isAttr;
            end
         endcase
      end
      return p;
   endfunction

   assign next_plan = decodePlan(attrNS, ceLoNS, ceHiNS, memStrobe, ioStrobe, addrS,
                                 nativeDiskMode, ioMappedConfig, eightBitMode);

   // ==========================================================
   // Plan register, taken once per strobe pulse
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         plan <= '0;
      end else if (rdStart || wrStart) begin
         plan <= next_plan;
      end
   end

   // ==========================================================
   // Power-up mode capture after the synchronisers settle
   always_ff @(posedge clk) begin // R12
      if (sys_rst) begin
         bootCnt <= 2'h0;
         nativeDiskMode <= 1'b0;
         modeValid <= 1'b0;
      end else if (!modeValid) begin
         if (bootCnt == cbl_pkg::MODE_SAMPLE_CYCLES) begin
            nativeDiskMode <= !oeNS;
            modeValid <= 1'b1;
         end else begin
            bootCnt <= bootCnt + 2'h1;
         end
      end
   end

   // ==========================================================
   // Access sequencer
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state <= cbl_pkg::ST_BOOT;
      end else begin
         unique case (state)
            cbl_pkg::ST_BOOT: if (modeValid) state <= cbl_pkg::ST_IDLE;
            cbl_pkg::ST_IDLE: begin
               if (rdStart) state <= cbl_pkg::ST_RD_ADDR;
               else if (wrStart) state <= cbl_pkg::ST_WR_HOLD;
            end
            cbl_pkg::ST_RD_ADDR: state <= cbl_pkg::ST_RD_LOAD;
            cbl_pkg::ST_RD_LOAD: state <= cbl_pkg::ST_RD_DRIVE;
            cbl_pkg::ST_RD_DRIVE: if (!rdActive) state <= cbl_pkg::ST_IDLE;
            cbl_pkg::ST_WR_HOLD: if (!wrActive) state <= cbl_pkg::ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Write commit on the strobe's trailing edge
   always_ff @(posedge clk) begin // R18
      if (sys_rst) begin
         tfWrEn <= 1'b0;
         attrWrEn <= 1'b0;
         tfByteEn <= 2'h0;
         wrWord <= cbl_pkg::WORD_ZERO;
         deviceControl <= cbl_pkg::DEV_CTRL_RESET;
      end else begin
         tfWrEn <= 1'b0;
         attrWrEn <= 1'b0;
         if (state == cbl_pkg::ST_WR_HOLD && !wrActive && plan.valid) begin
            tfWrEn <= !plan.attr && !plan.ctrl && (plan.wrLo || plan.wrHi); // R10
            attrWrEn <= plan.attr && plan.wrLo; // R4 R13
            tfByteEn <= {plan.wrHi, plan.wrLo}; // R17
            wrWord <= {plan.hiFromLo ? dataS[7:0] : dataS[15:8], dataS[7:0]}; // R8 R10
            if (plan.ctrl) deviceControl <= dataS[7:0]; // R16
         end
      end
   end

   // Register write addresses follow the plan
   assign tfWrAddr = plan.idx[3:0];
   assign attrWrAddr = plan.idx[6:0];

   // ==========================================================
   // Storage: task-file registers and attribute bytes
   cbl_lane_mem #(.W(cbl_pkg::DATA_W), .D(cbl_pkg::TF_DEPTH), .AW(cbl_pkg::TF_AW)) uTaskFile (
      .clk(clk),
      .wrEn(tfWrEn),
      .byteEn(tfByteEn),
      .wrAddr(tfWrAddr),
      .wrData(wrWord),
      .rdAddr(plan.idx[3:0]),
      .rdData(tfRd)
   );

   cbl_lane_mem #(.W(8), .D(cbl_pkg::ATTR_DEPTH), .AW(cbl_pkg::ATTR_AW)) uAttr (
      .clk(clk),
      .wrEn(attrWrEn),
      .byteEn(1'b1),
      .wrAddr(attrWrAddr),
      .wrData(wrWord[7:0]),
      .rdAddr(plan.idx[6:0]),
      .rdData(attrRd)
   );

   // ==========================================================
   // Read lane steering and drive enables
   assign srcWord = plan.attr ? {cbl_pkg::BYTE_ZERO, attrRd} : tfRd;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dataOut <= cbl_pkg::WORD_ZERO;
         dataOeLow <= 1'b0;
         dataOeHigh <= 1'b0;
      end else if (state == cbl_pkg::ST_RD_LOAD) begin
         dataOeLow <= plan.valid && plan.drvLo; // R6 R18
         dataOeHigh <= plan.valid && plan.drvHi;
         dataOut[15:8] <= plan.hiZero ? cbl_pkg::BYTE_ZERO : srcWord[15:8]; // R3 R9
         if (plan.useStat) dataOut[7:0] <= statusIn; // R16
         else if (plan.loZero) dataOut[7:0] <= cbl_pkg::BYTE_ZERO; // R2
         else if (plan.loFromHi) dataOut[7:0] <= srcWord[15:8]; // R7
         else dataOut[7:0] <= srcWord[7:0]; // R8
      end else if (state != cbl_pkg::ST_RD_DRIVE || !rdActive) begin
         dataOeLow <= 1'b0;
         dataOeHigh <= 1'b0;
      end
   end

   // ==========================================================
   // Assertions
   default clocking cbAsr @(posedge clk); endclocking
   default disable iff (sys_rst);

   assign rdLive = state == cbl_pkg::ST_RD_DRIVE;

   property p_attr_byte;
      rdLive && plan.attr && plan.ceN == 2'b10 |-> dataOeLow && !dataOeHigh;
   endproperty
   a_attr_byte: assert property (p_attr_byte) else $error("attr byte lanes"); // R2

   property p_attr_word_odd;
      rdLive && plan.attr && !plan.ceN[1]
         |-> dataOeHigh && dataOut[15:8] == 8'h00 && dataOeLow == !plan.ceN[0];
   endproperty
   a_attr_word_odd: assert property (p_attr_word_odd) else $error("attr word lanes"); // R3

   property p_attr_wr_even;
      attrWrEn |-> !$past(plan.ceN[0]) && (!$past(plan.ceN[1]) || !$past(plan.a0));
   endproperty
   a_attr_wr_even: assert property (p_attr_wr_even) else $error("attr odd write"); // R4

   property p_both_high_float;
      rdStart && !nativeDiskMode && ceLoNS && ceHiNS |-> ##3 !dataOeLow && !dataOeHigh;
   endproperty
   a_both_high_float: assert property (p_both_high_float) else $error("standby drove"); // R5

   property p_inhibit;
      (rdStart || wrStart) && !nativeDiskMode && ioMappedConfig && attrNS && ioStrobe
         |=> !plan.valid;
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("inhibit decoded"); // R6

   property p_task_byte;
      rdLive && plan.valid && !plan.attr && !nativeDiskMode && plan.ceN == 2'b10
         |-> dataOeLow && !dataOeHigh && dataOut[7:0] == (plan.a0 ? tfRd[15:8] : tfRd[7:0]);
   endproperty
   a_task_byte: assert property (p_task_byte) else $error("task byte lanes"); // R7

   property p_task_word;
      rdLive && plan.valid && !plan.attr && !nativeDiskMode && plan.ceN == 2'b00
         |-> dataOeLow && dataOeHigh && dataOut == tfRd;
   endproperty
   a_task_word: assert property (p_task_word) else $error("task word lanes"); // R8

   property p_task_odd;
      rdLive && plan.valid && !plan.attr && !nativeDiskMode && plan.ceN == 2'b01
         |-> dataOeHigh && !dataOeLow && dataOut[15:8] == tfRd[15:8];
   endproperty
   a_task_odd: assert property (p_task_odd) else $error("task odd lanes"); // R9

   property p_task_byte_wr;
      tfWrEn && !nativeDiskMode && $past(plan.ceN) == 2'b10
         |-> tfByteEn == {$past(plan.a0), !$past(plan.a0)}
             && (!$past(plan.a0) || wrWord[15:8] == wrWord[7:0]);
   endproperty
   a_task_byte_wr: assert property (p_task_byte_wr) else $error("byte write lane"); // R10

   property p_mem_cfg;
      (rdStart || wrStart) && !nativeDiskMode && !ioMappedConfig && memStrobe && attrNS
         && !(ceLoNS && ceHiNS) |=> plan.valid && !plan.attr;
   endproperty
   a_mem_cfg: assert property (p_mem_cfg) else $error("memory config miss"); // R11

   property p_mode_capture;
      $rose(modeValid) |-> nativeDiskMode == !$past(oeNS);
   endproperty
   a_mode_capture: assert property (p_mode_capture) else $error("mode capture"); // R12

   property p_native_no_attr;
      nativeDiskMode |-> !attrWrEn && !(rdLive && plan.attr);
   endproperty
   a_native_no_attr: assert property (p_native_no_attr) else $error("attr in native"); // R13

   property p_native_word;
      rdLive && nativeDiskMode && plan.valid && !eightBitMode && !plan.useStat
         && plan.idx[2:0] == 3'h0 |-> dataOeHigh && dataOeLow;
   endproperty
   a_native_word: assert property (p_native_word) else $error("data reg not word"); // R14

   property p_native_both_sel;
      rdStart && nativeDiskMode && !ceLoNS && !ceHiNS |=> !plan.valid ##2 !dataOeLow;
   endproperty
   a_native_both_sel: assert property (p_native_both_sel) else $error("both selects"); // R15

   property p_alt_status;
      rdLive && $past(state) == cbl_pkg::ST_RD_LOAD && plan.useStat
         |-> dataOut[7:0] == $past(statusIn) && !dataOeHigh;
   endproperty
   a_alt_status: assert property (p_alt_status) else $error("alt status"); // R16

   property p_native_wr_low;
      tfWrEn && nativeDiskMode && $past(plan.idx[2:0]) != 3'h0 |-> tfByteEn == 2'b01;
   endproperty
   a_native_wr_low: assert property (p_native_wr_low) else $error("upper lane write"); // R17

   property p_read_timing;
      rdStart ##1 rdActive[*2]
         |-> ##1 dataOeLow == plan.drvLo && dataOeHigh == plan.drvHi;
   endproperty
   a_read_timing: assert property (p_read_timing) else $error("read answer late"); // R18

   property p_one_write;
      tfWrEn |=> !tfWrEn;
   endproperty
   a_one_write: assert property (p_one_write) else $error("double write"); // R18

   cover property (rdLive && plan.attr && dataOeLow);
   cover property (tfWrEn && tfByteEn == 2'b11);
   cover property (rdLive && plan.useStat);
   cover property ($rose(modeValid) && nativeDiskMode);
endmodule // cbl_lane_decoder

/* File: rtl/cbl_lane_mem.sv */
// Small register-file memory with byte enables and registered read data
module cbl_lane_mem #(
   parameter int W = 16,
   parameter int D = 16,
   parameter int AW = 4
) (
   input wire logic clk,
   input wire logic wrEn,
   input wire logic [W/8-1:0] byteEn,
   input wire logic [AW-1:0] wrAddr,
   input wire logic [W-1:0] wrData,
   input wire logic [AW-1:0] rdAddr,
   output logic [W-1:0] rdData
);
   logic [W-1:0] store [D];

   // ==========================================================
   // Byte-wise write
   always_ff @(posedge clk) begin
      if (wrEn) begin
         for (int b = 0; b < W/8; b++) begin
            if (byteEn[b]) begin
               store[wrAddr][b*8 +: 8] <= wrData[b*8 +: 8];
            end
         end
      end
   end

   // Registered read port
   always_ff @(posedge clk) begin
      rdData <= store[rdAddr];
   end
endmodule // cbl_lane_mem

/* File: rtl/cbl_pkg.sv */
// Shared constants and types of the card bus lane decoder
package cbl_pkg;
   // ==========================================================
   // Widths and memory sizes
   localparam int DATA_W = 16;
   localparam int ADDR_W = 8;
   localparam int TF_DEPTH = 16;
   localparam int TF_AW = 4;
   localparam int ATTR_DEPTH = 128;
   localparam int ATTR_AW = 7;
   localparam int SYNC_STAGES = 2;

   // ==========================================================
   // Native disk mode register addresses
   localparam logic [3:0] TF_NATIVE_BASE = 4'h8;
   localparam logic [2:0] NATIVE_DATA_ADDR = 3'h0;
   localparam logic [2:0] NATIVE_CTRL_ADDR = 3'h6;

   // ==========================================================
   // Reset values and timing counts
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] DEV_CTRL_RESET = 8'h00;
   localparam logic [15:0] WORD_ZERO = 16'h0000;
   localparam logic [1:0] MODE_SAMPLE_CYCLES = 2'h3;

   // ==========================================================
   // Bit positions inside the synchronised pin vector
   localparam int PIN_W = 31;
   localparam int PIN_DATA_LSB = 0;
   localparam int PIN_ADDR_LSB = 16;
   localparam int PIN_IO_WRITE_STROBE = 24;
   localparam int PIN_IO_READ_STROBE = 25;
   localparam int PIN_WE = 26;
   localparam int PIN_OE = 27;
   localparam int PIN_CE_LO = 28;
   localparam int PIN_CE_HI = 29;
   localparam int PIN_ATTR = 30;

   // ==========================================================
   // Access sequencer states
   typedef enum logic [2:0] {
      ST_BOOT,
      ST_IDLE,
      ST_RD_ADDR,
      ST_RD_LOAD,
      ST_RD_DRIVE,
      ST_WR_HOLD
   } cbl_state_e;

   // Lane plan of one access, decided at the strobe edge
   typedef struct packed {
      logic valid;
      logic attr;
      logic drvLo;
      logic drvHi;
      logic loFromHi;
      logic loZero;
      logic hiZero;
      logic wrLo;
      logic wrHi;
      logic hiFromLo;
      logic useStat;
      logic ctrl;
      logic [1:0] ceN;
      logic a0;
      logic [7:0] idx;
   } cbl_plan_s;
endpackage : cbl_pkg

/* File: testbench/cbl_host_model.sv */
// Host controller model that drives the card pins one access at a time
module cbl_host_model (
   input wire logic clk,
   input wire logic strapLow,
   input wire logic [15:0] cardData,
   input wire logic cardOeLow,
   input wire logic cardOeHigh,
   output logic attrSelectN,
   output logic lowLaneCardEnableN,
   output logic highLaneCardEnableN,
   output logic outputEnableN,
   output logic writeEnableN,
   output logic ioReadStrobeN,
   output logic ioWriteStrobeN,
   output logic [7:0] cardAddr,
   output logic [15:0] dataIn
);
   timeunit 1ns;
   timeprecision 100ps;
   logic busy;

   // ==========================================================
   // Idle pin levels
   initial begin
      {attrSelectN, lowLaneCardEnableN, highLaneCardEnableN} = 3'h7;
      {outputEnableN, writeEnableN, ioReadStrobeN, ioWriteStrobeN} = 4'hF;
      cardAddr = 8'h00;
      dataIn = 16'h0000;
      busy = 1'h0;
   end

   // Memory read strobe idles at the power-up strap level
   always @(posedge clk) begin
      if (!busy) outputEnableN <= ~strapLow;
   end

   // ==========================================================
   // One access; f = {cfg, io, wr, attrN, hiN, loN}
   task automatic access(input logic [5:0] f, input logic [7:0] addr,
         input logic [15:0] wd, output logic [1:0] oe, output logic [15:0] rd);
      @(posedge clk);
      busy <= 1'h1;
      attrSelectN <= f[2];
      highLaneCardEnableN <= f[1];
      lowLaneCardEnableN <= f[0];
      cardAddr <= addr;
      dataIn <= f[3] ? wd : ~dataIn;
      repeat (2) @(posedge clk);
      // Only one strobe moves, the other three stay high
      if (f[4] && f[3]) ioWriteStrobeN <= 1'h0;
      else if (f[4]) ioReadStrobeN <= 1'h0;
      else if (f[3]) writeEnableN <= 1'h0;
      else outputEnableN <= 1'h0;
      repeat (8) @(posedge clk);
      oe = {cardOeHigh, cardOeLow};
      rd = cardData;
      {outputEnableN, writeEnableN, ioReadStrobeN, ioWriteStrobeN} <= 4'hF;
      repeat (4) @(posedge clk);
      // Released selects return high; the data lines show the inverse of their last value
      {attrSelectN, lowLaneCardEnableN, highLaneCardEnableN} <= 3'h7;
      dataIn <= ~dataIn;
      repeat (3) @(posedge clk);
      busy <= 1'h0;
   endtask
endmodule // cbl_host_model

/* File: testbench/tb_top.sv */
// Self-checking bench of the card bus lane decoder
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {
      logic [5:0] f;
      logic [7:0] addr;
      logic [15:0] d;
      logic [1:0] e;
   } cbl_row_s;
   logic clk, sys_rst, ioMappedConfig, eightBitMode, strapLow;
   logic [7:0] statusIn, cardAddr, deviceControl;
   logic attrSelectN, lowLaneCardEnableN, highLaneCardEnableN, outputEnableN;
   logic writeEnableN, ioReadStrobeN, ioWriteStrobeN, dataOeLow, dataOeHigh;
   logic nativeDiskMode, modeValid;
   logic [15:0] dataIn, dataOut;
   int num_errors, cmp_count, cycles;
   // Card-mode rows: flags, address, write data or expected read, lanes
   cbl_row_s rows [27] = '{
      '{6'h38, 8'h02, 16'hA55A, 2'h0}, '{6'h30, 8'h02, 16'hA55A, 2'h3},
      '{6'h32, 8'h02, 16'h005A, 2'h1}, '{6'h32, 8'h03, 16'h00A5, 2'h1},
      '{6'h31, 8'h02, 16'hA500, 2'h2}, '{6'h38, 8'h04, 16'h1234, 2'h0},
      '{6'h3A, 8'h05, 16'hC33C, 2'h0}, '{6'h30, 8'h04, 16'h3C34, 2'h3},
      '{6'h39, 8'h04, 16'h77EE, 2'h0}, '{6'h3C, 8'h04, 16'hFFFF, 2'h0},
      '{6'h3B, 8'h04, 16'h0000, 2'h0}, '{6'h30, 8'h04, 16'h7734, 2'h3},
      '{6'h34, 8'h04, 16'h0000, 2'h0}, '{6'h33, 8'h04, 16'h0000, 2'h0},
      '{6'h2A, 8'h00, 16'h00AA, 2'h0}, '{6'h2A, 8'h01, 16'h0011, 2'h0},
      '{6'h29, 8'h00, 16'hEE22, 2'h0}, '{6'h22, 8'h00, 16'h00AA, 2'h1},
      '{6'h22, 8'h01, 16'h0000, 2'h1}, '{6'h20, 8'h00, 16'h00AA, 2'h3},
      '{6'h21, 8'h00, 16'h0000, 2'h2}, '{6'h04, 8'h02, 16'hA55A, 2'h3},
      '{6'h0E, 8'h03, 16'h0099, 2'h0}, '{6'h04, 8'h02, 16'h995A, 2'h3},
      '{6'h10, 8'h02, 16'h0000, 2'h0}, '{6'h24, 8'h02, 16'h0000, 2'h0},
      '{6'h02, 8'h00, 16'h00AA, 2'h1}};
   // Native disk rows
   cbl_row_s nat [9] = '{
      '{6'h3E, 8'h00, 16'hBEEF, 2'h0}, '{6'h36, 8'h00, 16'hBEEF, 2'h3},
      '{6'h3E, 8'h03, 16'h9911, 2'h0}, '{6'h36, 8'h03, 16'h0011, 2'h1},
      '{6'h3D, 8'h06, 16'h0042, 2'h0}, '{6'h35, 8'h06, 16'h005C, 2'h1},
      '{6'h34, 8'h00, 16'h0000, 2'h0}, '{6'h22, 8'h00, 16'h0000, 2'h0},
      '{6'h35, 8'h05, 16'h0000, 2'h0}};

   // ==========================================================
   // Instances
   cbl_lane_decoder u_dut (.clk(clk), .sys_rst(sys_rst), .attrSelectN(attrSelectN),
      .lowLaneCardEnableN(lowLaneCardEnableN), .highLaneCardEnableN(highLaneCardEnableN),
      .outputEnableN(outputEnableN), .writeEnableN(writeEnableN),
      .ioReadStrobeN(ioReadStrobeN), .ioWriteStrobeN(ioWriteStrobeN),
      .cardAddr(cardAddr), .dataIn(dataIn), .ioMappedConfig(ioMappedConfig),
      .eightBitMode(eightBitMode), .statusIn(statusIn), .dataOut(dataOut),
      .dataOeLow(dataOeLow), .dataOeHigh(dataOeHigh), .deviceControl(deviceControl),
      .nativeDiskMode(nativeDiskMode), .modeValid(modeValid));
   cbl_host_model u_host (.clk(clk), .strapLow(strapLow), .cardData(dataOut),
      .cardOeLow(dataOeLow), .cardOeHigh(dataOeHigh), .attrSelectN(attrSelectN),
      .lowLaneCardEnableN(lowLaneCardEnableN), .highLaneCardEnableN(highLaneCardEnableN),
      .outputEnableN(outputEnableN), .writeEnableN(writeEnableN),
      .ioReadStrobeN(ioReadStrobeN), .ioWriteStrobeN(ioWriteStrobeN),
      .cardAddr(cardAddr), .dataIn(dataIn));

   // ==========================================================
   // Clock and hang guard
   initial begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         $display("timeout at %0t", $time);
         conclude();
      end
   end

   // ==========================================================
   // Checks and helpers
   task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp_lanes(input cbl_row_s r, input logic [1:0] oe, input logic [15:0] rd);
      logic [15:0] mask;
      mask = {{8{r.e[1]}}, {8{r.e[0]}}};
      cmp_val({14'h0000, oe}, {14'h0000, r.e});
      if (mask !== 16'h0000) cmp_val(rd & mask, r.d & mask);
   endtask
   task automatic run(input cbl_row_s r);
      logic [1:0] oe;
      logic [15:0] rd;
      ioMappedConfig <= r.f[5];
      u_host.access(r.f, r.addr, r.d, oe, rd);
      if (!r.f[3]) cmp_lanes(r, oe, rd);
   endtask
   // Reset with the strap held, then release the strap
   task automatic do_reset(input logic strap);
      strapLow <= strap;
      sys_rst <= 1'h1;
      repeat (12) @(posedge clk);
      sys_rst <= 1'h0;
      repeat (8) @(posedge clk);
      strapLow <= 1'h0;
      repeat (4) @(posedge clk);
   endtask
   task automatic conclude();
      $display("compares=%0d mismatches=%0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      sys_rst = 1'h1;
      ioMappedConfig = 1'h1;
      eightBitMode = 1'h0;
      statusIn = 8'h5C;
      strapLow = 1'h0;
      num_errors = 0;
      cmp_count = 0;
      cycles = 0;
      do_reset(1'h0);
      cmp_val({14'h0000, nativeDiskMode, modeValid}, 16'h0001);
      cmp_val({8'h00, deviceControl}, 16'h0000);
      $display("reset test done");
      foreach (rows[i]) begin
         run(rows[i]);
         $display("card row %0d done", i);
      end
      do_reset(1'h1);
      cmp_val({14'h0000, nativeDiskMode, modeValid}, 16'h0003);
      foreach (nat[i]) begin
         run(nat[i]);
         $display("native row %0d done", i);
      end
      cmp_val({8'h00, deviceControl}, 16'h0042);
      eightBitMode <= 1'h1;
      run('{6'h36, 8'h00, 16'h00EF, 2'h1});
      $display("eight-bit data port test done");
      conclude();
   end
endmodule // tb_top
